/* File: spdm_consts.svh */
// Constants of the speed, position and direction monitor
`ifndef SPDM_CONSTS_SVH
`define SPDM_CONSTS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ      250
`define GATE_US      1000
`define GATE_CYC     (`GATE_US * `CLK_MHZ)
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define N_FN         9
`define N_WIN        4
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define A_CTRL       12'h000
`define A_DIR_TOL    12'h004
`define A_RATIO      12'h008
`define A_ACT_SPEED  12'h00c
`define A_SHEAR_OFF  12'h010
`define A_WIN_WIDTH  12'h014
`define A_STATUS     12'h018
`define A_SPEED      12'h01c
`define A_POS        12'h020
`define A_FTAB       12'h400
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define C_SEL_NONE   0
`define C_POS_AUTO   1
`define C_DIR_ARST   2
`define C_ZMON       3
`define C_PROX       4
`define S_PERR       15
`define P_A          0
`define P_B          1
`define P_Z          2
`define P_OPEN       3
`define P_START      4
`define P_SEL        5
// ----------------------------------------------------------------
// Reset values and plausibility figures
// ----------------------------------------------------------------
`define DIR_TOL_RST  16'h0003
`define RATIO_ONE    16'h0100
`define TOL_Z_HALF   8'h0f
`define TOL_AB_HALF  8'h09
`define PCT_LIMIT    32'h0000000a
`endif

/* File: spdm_pkg.sv */
// Types of the speed, position and direction monitor
`include "spdm_consts.svh"
package spdm_pkg;
  // Kind of a switch function entry
  typedef enum logic [3:0] {
    FN_OFF, FN_ON, FN_STAND, FN_SPEED, FN_RANGE_HI, FN_RANGE_LO,
    FN_CW, FN_CCW, FN_POS
  } fn_type_t;

  // State of the monitor apart from the function table
  typedef struct packed {
    logic [8:0]       sync1;
    logic [8:0]       sync2;
    logic [8:0]       prev;
    logic [4:0]       ctrl;
    logic [15:0]      dir_tol;
    logic [15:0]      ratio;
    logic [15:0]      act_speed;
    logic [15:0]      shear_off;
    logic [31:0]      win_w;
    logic [3:0]       set;
    logic [31:0]      pos;
    logic [3:0][31:0] ref_pos;
    logic [3:0]       pos_act;
    logic [31:0]      gate_cnt;
    logic [15:0]      ab_acc;
    logic [15:0]      z_acc;
    logic [15:0]      ab_spd;
    logic [15:0]      z_spd;
    logic [8:0]       fn_out;
    logic             cw_ok;
    logic             ccw_ok;
    logic [15:0]      cw_wrong;
    logic [15:0]      cw_good;
    logic [15:0]      ccw_wrong;
    logic [15:0]      ccw_good;
    logic [7:0]       tol_half;
    logic             plaus_err;
    logic             ack;
    logic [31:0]      dat;
  } state_t;
endpackage

/* File: speed_position_direction_monitor.sv */
// Speed, position and direction monitoring core with Wishbone registers
// Summary of operation
// [R1] Standstill: on below value, off above
// [R2] Speed: off when limit exceeded
// [R3] Range: off outside upper/lower limits
// [R4] Nine functions evaluated concurrently
// [R5] Sixteen parameter sets, selected one used
// [R6] Start captures reference centred in window
// [R7] Four position windows monitored together
// [R8] Leaving window deactivates, outputs off
// [R9] Monitored start: rising edge, no retrigger
// [R10] Monitored: set change keeps or resets
// [R11] Automatic: edge or set change starts
// [R12] Automatic: set change restarts or deactivates
// [R13] Open circuit or proximity disables position
// [R14] Direction outputs on for correct rotation
// [R15] Wrong-direction tolerance, recover by tolerance
// [R16] Auto reset on set change, else power
// [R17] Direction always active, on from start-up
// [R18] AB versus Z differ under ten percent
// [R19] Plausibility needs speed, tolerance, not disabled
// [R20] Minimum speed from ratio and activation speed
// [R21] Tolerance 7.5 Z or 4.5 AB pulses
// [R22] Hysteresis applies at switch-on
// [R23] Four weighted select inputs, none ignores
// [R24] Quadrature phase order gives position, direction
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "spdm_consts.svh"
module speed_position_direction_monitor #(
  parameter int unsigned GATE_CYC = `GATE_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Encoder, start and select pins
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_z,
  input  wire logic        enc_open,
  input  wire logic        start_input_pin,
  input  wire logic        select_weight_one,
  input  wire logic        select_weight_two,
  input  wire logic        select_weight_four,
  input  wire logic        select_weight_eight,
  // Results
  output logic      [8:0]  fn_out,
  output logic      [3:0]  pos_active,
  output logic             cw_ok,
  output logic             ccw_ok,
  output logic             plaus_err
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spdm_pkg::state_t st;
  spdm_pkg::state_t next_st;
  logic [31:0]      ftab [0:255];
  logic [31:0]      cur_cfg [0:8];
  logic [31:0]      nxt_cfg [0:8];
  logic [3:0]       use_cur;
  logic [3:0]       use_nxt;
  logic [3:0]       nset;
  logic             set_chg;
  logic             up_step;
  logic             dn_step;
  logic             start_rise;
  logic             gate_tick;
  logic             plaus_act;
  logic             req;
  logic             wr;
  logic [8:0]       pin_raw;

  assign pin_raw = {select_weight_eight, select_weight_four, select_weight_two,
                    select_weight_one, start_input_pin, enc_open, enc_z, enc_b,
                    enc_a};
  assign req = wb_cyc_i & wb_stb_i;
  assign wr  = req & wb_we_i & st.ack;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = val[i*8 +: 8];
    end
    return r;
  endfunction

  // Tolerance tracker of one direction: {ok, wrong, good}
  function automatic logic [32:0] dir_upd(input logic ok, input logic [15:0] wrong,
                                          input logic [15:0] good, input logic fwd,
                                          input logic back, input logic [15:0] tol,
                                          input logic rst);
    logic        o;
    logic [15:0] w;
    logic [15:0] g;
    o = ok;
    w = wrong;
    g = good;
    if (back) begin
      if (o) begin
        w = w + 16'h0001;
        if (w > tol) begin  // [R15]
          o = 1'b0;
          g = 16'h0000;
        end
      end else g = 16'h0000;
    end else if (fwd) begin
      if (o) w = 16'h0000;
      else begin
        g = g + 16'h0001;
        if (g >= tol) begin  // [R15]
          o = 1'b1;
          w = 16'h0000;
        end
      end
    end
    // Reset clears the counts only; an off output still needs recovery
    if (rst) begin  // [R16]
      w = 16'h0000;
      g = 16'h0000;
    end
    return {o, w, g};
  endfunction

  // ----------------------------------------------------------------
  // Function table reads for current and incoming set
  // ----------------------------------------------------------------
  // All nine entries are read in parallel so every function runs at once
  for (genvar g = 0; g < `N_FN; g++) begin : g_cfg
    assign cur_cfg[g] = ftab[{st.set, 4'(g)}];  // [R4] [R5]
    assign nxt_cfg[g] = ftab[{nset, 4'(g)}];
  end

  // Which windows each set uses
  always_comb begin
    use_cur = 4'h0;
    use_nxt = 4'h0;
    for (int f = 0; f < `N_FN; f++) begin
      if (spdm_pkg::fn_type_t'(cur_cfg[f][19:16]) == spdm_pkg::FN_POS)
        use_cur[cur_cfg[f][21:20]] = 1'b1;
      if (spdm_pkg::fn_type_t'(nxt_cfg[f][19:16]) == spdm_pkg::FN_POS)
        use_nxt[nxt_cfg[f][21:20]] = 1'b1;
    end
  end

  // Function table storage, cleared at reset so no entry is undefined
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < 256; i++) ftab[i] <= 32'h00000000;
    end else if (wr && wb_adr_i >= `A_FTAB && wb_adr_i[5:2] < 4'(`N_FN)) begin
      ftab[wb_adr_i[9:2]] <= merge(ftab[wb_adr_i[9:2]], wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        a;
    logic        ach;
    logic        bch;
    logic        ge1;
    logic        min_ok;
    logic        on;
    logic        prox;
    logic [31:0] diff;
    logic [31:0] expd;
    logic [16:0] spd;
    logic [16:0] thr;
    logic [16:0] hys;
    logic [32:0] dv;
    a = st.sync2[`P_A];
    ach = a ^ st.prev[`P_A];
    bch = st.sync2[`P_B] ^ st.prev[`P_B];
    ge1 = st.ratio >= `RATIO_ONE;
    min_ok = 1'b0;
    on = 1'b0;
    prox = st.ctrl[`C_PROX];
    diff = 32'h00000000;
    expd = 32'h00000000;
    spd = {1'b0, st.ab_spd};
    thr = 17'h00000;
    hys = 17'h00000;
    dv = 33'h000000000;
    next_st = st;
    // Two flip-flops on every pin before use
    next_st.sync1 = pin_raw;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    // Quadrature decode: a single track change with its phase order
    up_step = (ach ^ bch) & (ach ? (a != st.sync2[`P_B]) : (a == st.sync2[`P_B]));  // [R24]
    dn_step = (ach ^ bch) & ~up_step;  // [R24]
    start_rise = st.sync2[`P_START] & ~st.prev[`P_START];
    if (!prox) begin
      if (up_step) next_st.pos = st.pos + 32'h00000001;
      else if (dn_step) next_st.pos = st.pos - 32'h00000001;
    end
    // Set selection; in select mode none set 0 holds
    nset = st.ctrl[`C_SEL_NONE] ? 4'h0 : st.sync2[`P_SEL +: 4];  // [R23]
    set_chg = nset != st.set;
    next_st.set = nset;  // [R5]
    // Frequency gate: pulses per gate give speed
    gate_tick = st.gate_cnt == GATE_CYC - 1;
    next_st.gate_cnt = gate_tick ? 32'h00000000 : st.gate_cnt + 32'h00000001;
    next_st.ab_acc = st.ab_acc + {15'h0000, a & ~st.prev[`P_A]};
    next_st.z_acc = st.z_acc + {15'h0000, st.sync2[`P_Z] & ~st.prev[`P_Z]};
    if (gate_tick) begin
      next_st.ab_spd = st.ab_acc;
      next_st.z_spd = st.z_acc;
      next_st.ab_acc = 16'h0000;
      next_st.z_acc = 16'h0000;
    end
    // Position windows, each independent
    for (int w = 0; w < `N_WIN; w++) begin  // [R7]
      diff = st.pos - st.ref_pos[w];
      if (diff[31]) diff = -diff;
      if (prox || st.sync2[`P_OPEN]) begin
        next_st.pos_act[w] = 1'b0;  // [R13]
      end else if (set_chg) begin
        if (!use_nxt[w]) next_st.pos_act[w] = 1'b0;  // [R10] [R12]
        else if (st.ctrl[`C_POS_AUTO]) begin
          next_st.pos_act[w] = 1'b1;  // [R11] [R12]
          next_st.ref_pos[w] = st.pos;
        end
      end else if (st.pos_act[w] && diff > {25'h0000000, st.win_w[w*8+1 +: 7]}) begin
        next_st.pos_act[w] = 1'b0;  // [R8]
      end else if (start_rise && !st.pos_act[w] && use_cur[w]) begin
        next_st.pos_act[w] = 1'b1;  // [R6] [R9] [R11]
        next_st.ref_pos[w] = st.pos;  // [R6]
      end
    end
    // Direction tracking runs regardless of the selected set
    dv = dir_upd(st.cw_ok, st.cw_wrong, st.cw_good, up_step, dn_step, st.dir_tol,
                 set_chg & st.ctrl[`C_DIR_ARST]);  // [R17]
    {next_st.cw_ok, next_st.cw_wrong, next_st.cw_good} = dv;
    dv = dir_upd(st.ccw_ok, st.ccw_wrong, st.ccw_good, dn_step, up_step, st.dir_tol,
                 set_chg & st.ctrl[`C_DIR_ARST]);  // [R17]
    {next_st.ccw_ok, next_st.ccw_wrong, next_st.ccw_good} = dv;
    // Switch functions with hysteresis on switch-on
    for (int f = 0; f < `N_FN; f++) begin
      on = st.fn_out[f];
      thr = {1'b0, cur_cfg[f][15:0]};
      hys = {9'h000, cur_cfg[f][31:24]};
      case (spdm_pkg::fn_type_t'(cur_cfg[f][19:16]))
        spdm_pkg::FN_ON: next_st.fn_out[f] = 1'b1;
        spdm_pkg::FN_STAND:
          next_st.fn_out[f] = on ? !(spd > thr) : (spd + hys < thr);  // [R1] [R22]
        spdm_pkg::FN_SPEED, spdm_pkg::FN_RANGE_HI:
          next_st.fn_out[f] = on ? !(spd > thr) : (spd + hys <= thr);  // [R2] [R3] [R22]
        spdm_pkg::FN_RANGE_LO:
          next_st.fn_out[f] = on ? !(spd < thr) : (spd >= thr + hys);  // [R3] [R22]
        spdm_pkg::FN_CW: next_st.fn_out[f] = st.cw_ok & ~prox;  // [R14] [R13]
        spdm_pkg::FN_CCW: next_st.fn_out[f] = st.ccw_ok & ~prox;  // [R14] [R13]
        spdm_pkg::FN_POS: next_st.fn_out[f] = next_st.pos_act[cur_cfg[f][21:20]];  // [R6] [R8]
        default: next_st.fn_out[f] = 1'b0;
      endcase
    end
    // Shearpin plausibility: minimum speed, then tolerance pulses
    min_ok = (ge1 ? st.z_spd != 16'h0000 : st.ab_spd != 16'h0000)
             && st.ab_spd >= st.act_speed;  // [R20]
    if (!min_ok) next_st.tol_half = 8'h00;
    else if (st.tol_half < (ge1 ? `TOL_Z_HALF : `TOL_AB_HALF)
             && (ge1 ? st.sync2[`P_Z] & ~st.prev[`P_Z] : a & ~st.prev[`P_A]))
      next_st.tol_half = st.tol_half + 8'h02;  // [R21]
    plaus_act = st.ctrl[`C_ZMON] & ~prox & ~st.shear_off[st.set] & min_ok
                & (st.tol_half >= (ge1 ? `TOL_Z_HALF : `TOL_AB_HALF));  // [R19]
    expd = (32'(st.z_spd) * 32'(st.ratio)) >> 8;
    diff = {16'h0000, st.ab_spd} - expd;
    if (diff[31]) diff = -diff;
    // Wishbone: registered ack one cycle after the request
    next_st.ack = req & ~st.ack;
    if (req && !st.ack) begin
      if (wb_adr_i == `A_CTRL) next_st.dat = {27'h0000000, st.ctrl};
      else if (wb_adr_i == `A_DIR_TOL) next_st.dat = {16'h0000, st.dir_tol};
      else if (wb_adr_i == `A_RATIO) next_st.dat = {16'h0000, st.ratio};
      else if (wb_adr_i == `A_ACT_SPEED) next_st.dat = {16'h0000, st.act_speed};
      else if (wb_adr_i == `A_SHEAR_OFF) next_st.dat = {16'h0000, st.shear_off};
      else if (wb_adr_i == `A_WIN_WIDTH) next_st.dat = st.win_w;
      else if (wb_adr_i == `A_STATUS)
        next_st.dat = {12'h000, st.set, st.plaus_err, st.ccw_ok, st.cw_ok,
                       st.pos_act, st.fn_out};
      else if (wb_adr_i == `A_SPEED) next_st.dat = {st.z_spd, st.ab_spd};
      else if (wb_adr_i == `A_POS) next_st.dat = st.pos;
      else if (wb_adr_i >= `A_FTAB && wb_adr_i[5:2] < 4'(`N_FN))
        next_st.dat = ftab[wb_adr_i[9:2]];
      else next_st.dat = 32'h00000000;  // Unmapped reads zero
    end
    if (wr) begin
      if (wb_adr_i == `A_CTRL) next_st.ctrl = 5'(merge(32'(st.ctrl), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `A_DIR_TOL)
        next_st.dir_tol = 16'(merge(32'(st.dir_tol), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `A_RATIO)
        next_st.ratio = 16'(merge(32'(st.ratio), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `A_ACT_SPEED)
        next_st.act_speed = 16'(merge(32'(st.act_speed), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `A_SHEAR_OFF)
        next_st.shear_off = 16'(merge(32'(st.shear_off), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == `A_WIN_WIDTH) next_st.win_w = merge(st.win_w, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `A_STATUS && wb_sel_i[1] && wb_dat_i[`S_PERR])
        next_st.plaus_err = 1'b0;  // Write one to clear
    end
    // A new error wins over a clear in the same cycle
    if (plaus_act && gate_tick && diff * `PCT_LIMIT >= expd) next_st.plaus_err = 1'b1;  // [R18]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
      st.dir_tol <= `DIR_TOL_RST;
      st.ratio <= `RATIO_ONE;
      st.cw_ok <= 1'b1;  // [R17]
      st.ccw_ok <= 1'b1;  // [R17]
    end else st <= next_st;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign fn_out = st.fn_out;
  assign pos_active = st.pos_act;
  assign cw_ok = st.cw_ok;
  assign ccw_ok = st.ccw_ok;
  assign plaus_err = st.plaus_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge clk_sys) disable iff (!nrst) s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_open;
    @(posedge clk_sys) disable iff (!nrst) st.sync2[`P_OPEN] |=> pos_active == 4'h0;
  endproperty
  a_open: assert property (p_open) else $error("window active on open circuit");  // [R13]
  property p_sel;
    @(posedge clk_sys) disable iff (!nrst)
      st.ctrl[`C_SEL_NONE] ##1 st.ctrl[`C_SEL_NONE] |-> st.set == 4'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("set moved in select none");  // [R23]
  property p_start;
    @(posedge clk_sys) disable iff (!nrst)
      start_rise && !set_chg && !st.ctrl[`C_PROX] && !st.sync2[`P_OPEN]
      && use_cur[0] && !pos_active[0] |=> pos_active[0] && st.ref_pos[0] == $past(st.pos);
  endproperty
  a_start: assert property (p_start) else $error("start edge ignored");  // [R9]
  property p_cwoff;
    @(posedge clk_sys) disable iff (!nrst) $fell(cw_ok) |-> $past(dn_step);
  endproperty
  a_cwoff: assert property (p_cwoff) else $error("cw off without wrong move");  // [R15]
  property p_perr;
    @(posedge clk_sys) disable iff (!nrst) $rose(plaus_err) |-> $past(plaus_act && gate_tick);
  endproperty
  a_perr: assert property (p_perr) else $error("error without active check");  // [R19]
  property p_speed;
    @(posedge clk_sys) disable iff (!nrst)
      spdm_pkg::fn_type_t'(cur_cfg[2][19:16]) == spdm_pkg::FN_SPEED
      && st.ab_spd > cur_cfg[2][15:0] |=> !fn_out[2];
  endproperty
  a_speed: assert property (p_speed) else $error("speed output stays on");  // [R2]
  property p_auto;
    @(posedge clk_sys) disable iff (!nrst)
      set_chg && use_nxt[0] && st.ctrl[`C_POS_AUTO] && !st.ctrl[`C_PROX]
      && !st.sync2[`P_OPEN] |=> pos_active[0];
  endproperty
  a_auto: assert property (p_auto) else $error("no restart on set change");  // [R12]
endmodule // speed_position_direction_monitor

/* File: spdm_encoder_model.sv */
// Quadrature encoder model driving the monitor's track inputs
`timescale 1ns/1ps
module spdm_encoder_model (
  // Clock
  input  wire logic clk_sys,
  // Tracks
  output logic      enc_a,
  output logic      enc_b,
  output logic      enc_z
);
  // ------------------------------------------------------------
  // Stepping
  // ------------------------------------------------------------
  logic [1:0] phase = 2'h0;

  // Gray order: A leads B when counting up; one index pulse per cycle
  assign enc_a = phase[1] ^ phase[0];
  assign enc_b = phase[1];
  assign enc_z = (phase == 2'h3);

  // Each level stands two clocks so the two-stage sync never drops one
  task automatic move(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      phase <= up ? phase + 2'h1 : phase - 2'h1;
      @(posedge clk_sys);
    end
  endtask
endmodule // spdm_encoder_model

/* File: speed_position_direction_monitor_tb_top.sv */
// Directed testbench of the speed, position and direction monitor
`timescale 1ns/1ps
`include "spdm_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module speed_position_direction_monitor_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int unsigned GATE = 64; // Short gate keeps speeds small
  logic        clk_sys             = 1'b0;
  logic        nrst                = 1'b0;
  logic [11:0] wb_adr_i            = 12'h000;
  logic [31:0] wb_dat_i            = 32'h0;
  logic [3:0]  wb_sel_i            = 4'h0;
  logic        wb_we_i             = 1'b0;
  logic        wb_cyc_i            = 1'b0;
  logic        wb_stb_i            = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        enc_a;
  logic        enc_b;
  logic        enc_z;
  logic        enc_open            = 1'b0;
  logic        start_input_pin     = 1'b0;
  logic        select_weight_one   = 1'b0;
  logic        select_weight_two   = 1'b0;
  logic        select_weight_four  = 1'b0;
  logic        select_weight_eight = 1'b0;
  logic [8:0]  fn_out;
  logic [3:0]  pos_active;
  logic        cw_ok;
  logic        ccw_ok;
  logic        plaus_err;
  int          err_total           = 0;
  int          n_tests             = 0;
  // Set 0: on, standstill 2, speed 4, lower 5, position 0, speed 4 hys 5, cw, ccw
  logic [31:0] tab [8] = '{32'h00010000, 32'h00020002, 32'h00030004, 32'h00050005,
                           32'h00080000, 32'h05030004, 32'h00060000, 32'h00070000};

  always #2 clk_sys = ~clk_sys;

  speed_position_direction_monitor #(.GATE_CYC(GATE)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_a(enc_a), .enc_b(enc_b),
    .enc_z(enc_z), .enc_open(enc_open), .start_input_pin(start_input_pin),
    .select_weight_one(select_weight_one), .select_weight_two(select_weight_two),
    .select_weight_four(select_weight_four), .select_weight_eight(select_weight_eight),
    .fn_out(fn_out), .pos_active(pos_active), .cw_ok(cw_ok), .ccw_ok(ccw_ok),
    .plaus_err(plaus_err));

  spdm_encoder_model enc (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // One classic cycle; ends one edge after release so strobes never re-assert at once
  task automatic bus(input logic [11:0] adr, input logic we, input logic [31:0] wd,
                     input logic [3:0] sel, output logic [31:0] rd);
    wb_adr_i <= adr;
    wb_we_i  <= we;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] adr, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] x;
    bus(adr, 1'b1, d, s, x);
  endtask
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(adr, 1'b0, 32'h0, 4'hf, x);
    `CHK(x & m, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Pins need three edges to act plus one for the outputs
  task automatic mv(input int n, input logic up);
    enc.move(n, up);
    idle(5);
  endtask
  task automatic pulse_start();
    start_input_pin <= 1'b1;
    idle(4);
    start_input_pin <= 1'b0;
    idle(4);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    idle(6);
    nrst <= 1'b1;
    idle(1);
    `CHK({cw_ok, ccw_ok, fn_out, pos_active}, 15'h6000)
    rd_chk(`A_DIR_TOL, 32'hffffffff, {16'h0, `DIR_TOL_RST});
    rd_chk(`A_RATIO, 32'hffffffff, {16'h0, `RATIO_ONE});
    wr(12'h100, 32'hffffffff);
    rd_chk(12'h100, 32'hffffffff, 32'h0);
    wr(`A_WIN_WIDTH, 32'h0000ff08, 4'h1);
    rd_chk(`A_WIN_WIDTH, 32'h0000ffff, 32'h00000008);
    foreach (tab[i]) wr(`A_FTAB + 12'(i * 4), tab[i]);
    idle(GATE + 8);
    `CHK(fn_out, 9'h0c7)
    // About eight rising A edges per gate while spinning up
    fork
      enc.move(80, 1'b1);
      begin
        idle(150);
        `CHK(fn_out, 9'h049)
      end
    join
    idle(5);
    mv(3, 1'b0);
    `CHK({cw_ok, ccw_ok}, 2'b11)
    mv(1, 1'b0);
    `CHK({cw_ok, ccw_ok}, 2'b01)
    mv(2, 1'b1);
    `CHK(cw_ok, 1'b0)
    mv(1, 1'b1);
    `CHK(cw_ok, 1'b1)
    // Window of width 8: four steps stay inside, five leave
    pulse_start();
    `CHK({pos_active[0], fn_out[4]}, 2'b11)
    mv(3, 1'b1);
    pulse_start();
    mv(1, 1'b1);
    `CHK(pos_active[0], 1'b1)
    mv(1, 1'b1);
    `CHK({pos_active[0], fn_out[4]}, 2'b00)
    pulse_start();
    `CHK(pos_active[0], 1'b1)
    select_weight_one <= 1'b1;
    idle(6);
    `CHK({pos_active, fn_out}, 13'h0)
    rd_chk(`A_STATUS, 32'h000f0000, 32'h00010000);
    wr(`A_CTRL, 32'h1);
    rd_chk(`A_STATUS, 32'h000f0000, 32'h0);
    wr(`A_CTRL, 32'h2);
    idle(6);
    select_weight_one <= 1'b0;
    idle(6);
    `CHK(pos_active[0], 1'b1)
    enc_open <= 1'b1;
    idle(6);
    `CHK(pos_active[0], 1'b0)
    // Plausibility: partial gates at start and stop differ by a count,
    // so the check is enabled on steady speed and disabled before stopping
    fork
      enc.move(200, 1'b1);
      begin
        idle(200);
        wr(`A_CTRL, 32'h0000000a);
        idle(70);
        `CHK(plaus_err, 1'b0)
        wr(`A_RATIO, 32'h00000200);
        idle(70);
        `CHK(plaus_err, 1'b1)
        wr(`A_CTRL, 32'h00000002);
        wr(`A_STATUS, 32'h00008000);
        `CHK(plaus_err, 1'b0)
      end
    join
    report_and_stop();
  end

  // Watchdog: the sequence needs about 800 cycles
  initial begin
    idle(5000);
    err_total++;
    report_and_stop();
  end
endmodule // speed_position_direction_monitor_tb_top
